// ---- rtl/interrupt_priority_fields.sv ----
// Priority-level registers and tagging of source requests
`timescale 1ns/100ps
`default_nettype none
module interrupt_priority_fields #(
    parameter int NUM_SRC = prio_pkg::NUM_SRC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [prio_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [prio_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [prio_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [NUM_SRC-1:0] src_request,
    output prio_pkg::req_s [NUM_SRC-1:0] src_tagged
);
    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [prio_pkg::DATA_W-1:0] fcv_q;
    logic [prio_pkg::DATA_W-1:0] can_q;
    logic [prio_pkg::DATA_W-1:0] spg_q;
    logic [prio_pkg::DATA_W-1:0] rdata_q;
    logic [prio_pkg::DATA_W-1:0] rdata_d;
    logic [1:0] field_code [NUM_SRC];

    // Write enables per register
    logic wr_fcv;
    logic wr_can;
    logic wr_spg;
    assign wr_fcv = reg_wr && (reg_addr == prio_pkg::ADDR_FCV);
    assign wr_can = reg_wr && (reg_addr == prio_pkg::ADDR_CAN);
    assign wr_spg = reg_wr && (reg_addr == prio_pkg::ADDR_SPG);

    // Flash, clock and voltage register; reserved bits never stored
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fcv_q <= prio_pkg::RESET_VAL;
        end
        else if (wr_fcv)
        begin
            fcv_q <= reg_wdata & prio_pkg::MASK_FCV;
        end
    end

    // CAN sources register
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            can_q <= prio_pkg::RESET_VAL;
        end
        else if (wr_can)
        begin
            can_q <= reg_wdata & prio_pkg::MASK_CAN;
        end
    end

    // Serial and GPIO port register
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            spg_q <= prio_pkg::RESET_VAL;
        end
        else if (wr_spg)
        begin
            spg_q <= reg_wdata & prio_pkg::MASK_SPG;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Unmapped addresses read zero rather than stale data
    always_comb
    begin
        rdata_d = '0;
        case (reg_addr)
            prio_pkg::ADDR_FCV: rdata_d = fcv_q;
            prio_pkg::ADDR_CAN: rdata_d = can_q;
            prio_pkg::ADDR_SPG: rdata_d = spg_q;
            default: rdata_d = '0;
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata_q <= '0;
        end
        else if (reg_rd)
        begin
            rdata_q <= rdata_d;
        end
        else
        begin
            rdata_q <= '0;
        end
    end
    assign reg_rdata = rdata_q;

    // ----------------------------------------------------------------
    // Field extraction
    // ----------------------------------------------------------------
    logic [1:0] flash_error_level;
    logic [1:0] pll_unlock_level;
    logic [1:0] low_voltage_level;
    logic [1:0] external_request_a_level;
    logic [1:0] can_msg_buffer_level;
    logic [1:0] can_wakeup_level;
    logic [1:0] can_error_level;
    logic [1:0] can_bus_off_level;
    logic [1:0] serial_port0_rx_full_level;
    logic [1:0] serial_port1_tx_empty_level;
    logic [1:0] serial_port1_rx_full_level;
    logic [1:0] port_a_pin_level;
    logic [1:0] port_b_pin_level;
    logic [1:0] port_c_pin_level;

    // Flash, clock and voltage fields
    assign flash_error_level =
        fcv_q[prio_pkg::LSB_FLASH_ERR +: 2];
    assign pll_unlock_level =
        fcv_q[prio_pkg::LSB_PLL_UNLOCK +: 2];
    assign low_voltage_level =
        fcv_q[prio_pkg::LSB_LOW_VOLT +: 2];
    assign external_request_a_level =
        fcv_q[prio_pkg::LSB_EXT_A +: 2];

    // CAN fields
    assign can_msg_buffer_level =
        can_q[prio_pkg::LSB_CAN_MSG +: 2];
    assign can_wakeup_level =
        can_q[prio_pkg::LSB_CAN_WAKE +: 2];
    assign can_error_level =
        can_q[prio_pkg::LSB_CAN_ERR +: 2];
    assign can_bus_off_level =
        can_q[prio_pkg::LSB_CAN_BOFF +: 2];

    // Serial and GPIO fields
    assign serial_port0_rx_full_level =
        spg_q[prio_pkg::LSB_SP0_RX +: 2];
    assign serial_port1_tx_empty_level =
        spg_q[prio_pkg::LSB_SP1_TX +: 2];
    assign serial_port1_rx_full_level =
        spg_q[prio_pkg::LSB_SP1_RX +: 2];
    assign port_a_pin_level =
        spg_q[prio_pkg::LSB_PORT_A +: 2];
    assign port_b_pin_level =
        spg_q[prio_pkg::LSB_PORT_B +: 2];
    assign port_c_pin_level =
        spg_q[prio_pkg::LSB_PORT_C +: 2];

    // Source index order matches src_request bit order
    assign field_code[0] = flash_error_level;
    assign field_code[1] = pll_unlock_level;
    assign field_code[2] = low_voltage_level;
    assign field_code[3] = external_request_a_level;
    assign field_code[4] = can_msg_buffer_level;
    assign field_code[5] = can_wakeup_level;
    assign field_code[6] = can_error_level;
    assign field_code[7] = can_bus_off_level;
    assign field_code[8] = serial_port0_rx_full_level;
    assign field_code[9] = serial_port1_tx_empty_level;
    assign field_code[10] = serial_port1_rx_full_level;
    assign field_code[11] = port_a_pin_level;
    assign field_code[12] = port_b_pin_level;
    assign field_code[13] = port_c_pin_level;

    // ----------------------------------------------------------------
    // Request tagging
    // ----------------------------------------------------------------
    // One registered slot per source; adds a cycle but keeps outputs
    // glitch free toward the arbiter
    for (genvar i = 0; i < NUM_SRC; i++)
    begin : g_slot
        priority_slot u_slot (
            .mclk(mclk),
            .reset_n(reset_n),
            .code(field_code[i]),
            .request(src_request[i]),
            .tagged_q(src_tagged[i])
        );
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    // First cycle out of reset, for the reset-state check
    logic first_q;
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            first_q <= 1'b1;
        end
        else
        begin
            first_q <= 1'b0;
        end
    end

    // Write to an address followed at once by a read of it
    sequence s_wr_then_rd(logic [prio_pkg::ADDR_W-1:0] a);
        reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
    endsequence

    // A write to a register, then a request of a source
    sequence s_wr_then_req(logic [prio_pkg::ADDR_W-1:0] a, int s);
        reg_wr && reg_addr == a ##1 src_request[s];
    endsequence

    for (genvar i = 0; i < NUM_SRC; i++)
    begin : g_chk
        chk_level_decode: assert property (
            src_request[i] && field_code[i] != prio_pkg::CODE_OFF |=>
            src_tagged[i].valid &&
            src_tagged[i].level == $past(field_code[i]) - 2'h1)
        else $error("level does not match configured code");

        chk_disabled_quiet: assert property (
            field_code[i] == prio_pkg::CODE_OFF || !src_request[i]
            |=> !src_tagged[i].valid)
        else $error("disabled or idle source raised a request");

        chk_tag_source: assert property (
            src_tagged[i].valid |-> $past(src_request[i]) &&
            $past(field_code[i]) != prio_pkg::CODE_OFF)
        else $error("tagged request without an enabled request");

        chk_no_level3: assert property (
            src_tagged[i].valid |-> src_tagged[i].level != 2'h3)
        else $error("level beyond two presented");
    end

    chk_reserved_zero: assert property (
        reg_rd |=> (reg_rdata & ~($past(reg_addr) ==
        prio_pkg::ADDR_FCV ? prio_pkg::MASK_FCV :
        $past(reg_addr) == prio_pkg::ADDR_CAN ? prio_pkg::MASK_CAN :
        prio_pkg::MASK_SPG)) == '0)
    else $error("reserved bits read back nonzero");

    chk_reset_disabled: assert property (
        first_q |-> fcv_q == '0 && can_q == '0 && spg_q == '0 &&
        src_tagged == '0)
    else $error("source enabled after reset");

    chk_flash_err_field: assert property (
        s_wr_then_rd(prio_pkg::ADDR_FCV) |=>
        reg_rdata[11:10] == $past(reg_wdata[11:10], 2))
    else $error("flash error field misplaced");

    chk_pll_field: assert property (
        s_wr_then_req(prio_pkg::ADDR_FCV, 1) |=>
        src_tagged[1].valid == ($past(reg_wdata[9:8], 2) != 2'h0))
    else $error("pll unlock field misplaced");

    chk_low_volt_field: assert property (
        reg_wr && reg_addr == prio_pkg::ADDR_FCV |=>
        low_voltage_level == $past(reg_wdata[7:6]))
    else $error("low voltage field misplaced");

    chk_ext_a_field: assert property (
        s_wr_then_rd(prio_pkg::ADDR_FCV) |=>
        reg_rdata[1:0] == $past(reg_wdata[1:0], 2) &&
        reg_rdata[5:2] == 4'h0)
    else $error("external A field or reserved bits wrong");

    chk_can_msg_field: assert property (
        s_wr_then_rd(prio_pkg::ADDR_CAN) |=>
        reg_rdata[9:8] == $past(reg_wdata[9:8], 2) &&
        reg_rdata[15:10] == 6'h00)
    else $error("CAN buffer field or reserved bits wrong");

    chk_can_wake_field: assert property (
        s_wr_then_req(prio_pkg::ADDR_CAN, 5) |=>
        src_tagged[5].valid == ($past(reg_wdata[7:6], 2) != 2'h0))
    else $error("CAN wake-up field misplaced");

    chk_can_err_field: assert property (
        reg_wr && reg_addr == prio_pkg::ADDR_CAN |=>
        can_error_level == $past(reg_wdata[5:4]))
    else $error("CAN error field misplaced");

    chk_can_boff_field: assert property (
        s_wr_then_rd(prio_pkg::ADDR_CAN) |=>
        reg_rdata[3:2] == $past(reg_wdata[3:2], 2) &&
        reg_rdata[1:0] == 2'h0)
    else $error("CAN bus-off field or reserved bits wrong");

    chk_sp0_rx_field: assert property (
        s_wr_then_rd(prio_pkg::ADDR_SPG) |=>
        reg_rdata[15:14] == $past(reg_wdata[15:14], 2))
    else $error("port 0 receive field misplaced");

    chk_sp1_tx_field: assert property (
        s_wr_then_req(prio_pkg::ADDR_SPG, 9) |=>
        src_tagged[9].valid == ($past(reg_wdata[13:12], 2) != 2'h0))
    else $error("port 1 transmit field misplaced");

    chk_sp1_rx_field: assert property (
        s_wr_then_rd(prio_pkg::ADDR_SPG) |=>
        reg_rdata[11:10] == $past(reg_wdata[11:10], 2) &&
        reg_rdata[9:6] == 4'h0)
    else $error("port 1 receive field or reserved bits wrong");

    chk_port_a_field: assert property (
        reg_wr && reg_addr == prio_pkg::ADDR_SPG |=>
        port_a_pin_level == $past(reg_wdata[5:4]))
    else $error("port A field misplaced");

    chk_port_b_field: assert property (
        reg_wr && reg_addr == prio_pkg::ADDR_SPG |=>
        port_b_pin_level == $past(reg_wdata[3:2]))
    else $error("port B field misplaced");

    chk_port_c_field: assert property (
        s_wr_then_req(prio_pkg::ADDR_SPG, 13) |=>
        src_tagged[13].valid == ($past(reg_wdata[1:0], 2) != 2'h0))
    else $error("port C field misplaced");

    // Read data of the serial and GPIO register mirror the stored word as it stood at the strobe
    chk_read_mirror: assert property (
        reg_rd && reg_addr == prio_pkg::ADDR_SPG |=>
        reg_rdata == $past(spg_q))
    else $error("read data differ from the register");

    chk_rdata_window: assert property (
        !reg_rd |=> reg_rdata == '0)
    else $error("read data outside its cycle");

endmodule // interrupt_priority_fields
`default_nettype wire

// ---- rtl/prio_pkg.sv ----
// Constants and types for the interrupt priority-level fields
// Function
// - code 00 off, 01-11 give levels 0-2
// - reserved bits read zero, writes dropped
// - levels 0-2 only; reset leaves all disabled
// - flash error code in bits 11:10
// - PLL unlock code in bits 9:8
// - low voltage code in bits 7:6
// - external A in 1:0; 5:2 reserved
// - CAN buffer in 9:8; 15:10 reserved
// - CAN wake-up code in bits 7:6
// - CAN bus-off in 3:2; 1:0 reserved
// - port 0 receive full in 15:14
// - port 1 transmit empty in 13:12
// - port 1 receive in 11:10; 9:6 reserved
// - GPIO port A code in bits 5:4
// - GPIO port B code in bits 3:2
// - GPIO port C code in bits 1:0
`default_nettype none
package prio_pkg;
    // ----------------------------------------------------------------
    // Bus and register map
    // ----------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 5;
    localparam int NUM_SRC = 14;
    localparam logic [ADDR_W-1:0] ADDR_FCV = 5'h02;
    localparam logic [ADDR_W-1:0] ADDR_CAN = 5'h03;
    localparam logic [ADDR_W-1:0] ADDR_SPG = 5'h04;
    localparam logic [DATA_W-1:0] RESET_VAL = 16'h0000;
    // Writable bits; all others are reserved
    localparam logic [DATA_W-1:0] MASK_FCV = 16'h0fc3;
    localparam logic [DATA_W-1:0] MASK_CAN = 16'h03fc;
    localparam logic [DATA_W-1:0] MASK_SPG = 16'hfc3f;
    // ----------------------------------------------------------------
    // Field low-bit positions
    // ----------------------------------------------------------------
    localparam int LSB_FLASH_ERR = 10;
    localparam int LSB_PLL_UNLOCK = 8;
    localparam int LSB_LOW_VOLT = 6;
    localparam int LSB_EXT_A = 0;
    localparam int LSB_CAN_MSG = 8;
    localparam int LSB_CAN_WAKE = 6;
    localparam int LSB_CAN_ERR = 4;
    localparam int LSB_CAN_BOFF = 2;
    localparam int LSB_SP0_RX = 14;
    localparam int LSB_SP1_TX = 12;
    localparam int LSB_SP1_RX = 10;
    localparam int LSB_PORT_A = 4;
    localparam int LSB_PORT_B = 2;
    localparam int LSB_PORT_C = 0;
    // ----------------------------------------------------------------
    // Codes, levels and the tagged request
    // ----------------------------------------------------------------
    localparam logic [1:0] CODE_OFF = 2'h0;
    localparam logic [1:0] CODE_LVL0 = 2'h1;
    localparam logic [1:0] CODE_LVL1 = 2'h2;
    localparam logic [1:0] CODE_LVL2 = 2'h3;
    typedef enum logic [1:0] {
        LVL0 = 2'b00,
        LVL1 = 2'b01,
        LVL2 = 2'b10
    } level_e;
    typedef struct packed {
        logic valid;
        level_e level;
    } req_s;
    // Code 00 is the only disabled code
    function automatic logic code_enabled(input logic [1:0] code);
        return code != CODE_OFF;
    endfunction
    // Level 3 cannot be produced by any code
    function automatic level_e code_level(input logic [1:0] code);
        case (code)
            CODE_LVL1: return LVL1;
            CODE_LVL2: return LVL2;
            default: return LVL0;
        endcase
    endfunction
endpackage
`default_nettype wire

// ---- rtl/priority_slot.sv ----
// One source: registered request tagged with its level
`timescale 1ns/100ps
`default_nettype none
module priority_slot (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [1:0] code,
    input wire logic request,
    output prio_pkg::req_s tagged_q
);
    // Disabled sources are gated here, so arbitration never sees them
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tagged_q <= '0;
        end
        else
        begin
            tagged_q.valid <= request && prio_pkg::code_enabled(code);
            tagged_q.level <= prio_pkg::code_level(code);
        end
    end
endmodule // priority_slot
`default_nettype wire

// ---- sim/irq_core_model.sv ----
// Behavioural core that takes the tagged requests of the priority fields
`timescale 1ns/100ps
`default_nettype none
module irq_core_model #(
    parameter int NUM_SRC = prio_pkg::NUM_SRC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire prio_pkg::req_s [NUM_SRC-1:0] src_tagged,
    output logic [31:0] taken_count,
    output logic bad_level
);
    logic [31:0] n_now;
    logic bad_now;

    // Count requests shown this cycle; level 3 is never a legal tag
    always_comb
    begin
        n_now = 32'h0000_0000;
        bad_now = 1'b0;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (src_tagged[i].valid === 1'b1)
            begin
                n_now = n_now + 32'h0000_0001;
                bad_now = bad_now | (src_tagged[i].level === 2'b11);
            end
        end
    end

    // The core accepts every request in the cycle it is shown, no stall
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            taken_count <= 32'h0000_0000;
            bad_level <= 1'b0;
        end
        else
        begin
            taken_count <= taken_count + n_now;
            bad_level <= bad_level | bad_now;
        end
    end
endmodule // irq_core_model
`default_nettype wire

// ---- sim/tb_interrupt_priority_fields.sv ----
// Self-checking testbench for the interrupt priority-level fields
`timescale 1ns/100ps
`default_nettype none
module tb_interrupt_priority_fields;
    localparam int NS = prio_pkg::NUM_SRC;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [NS-1:0] src_request = '0;
    prio_pkg::req_s [NS-1:0] src_tagged;
    logic [31:0] taken_count;
    logic bad_level;
    int n_mismatch = 0;
    int tests_run = 0;
    // Register index and low bit of each source field, in port bit order
    logic [4:0] src_addr [NS] = '{5'h02, 5'h02, 5'h02, 5'h02, 5'h03, 5'h03,
        5'h03, 5'h03, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04};
    int src_lsb [NS] = '{10, 8, 6, 0, 8, 6, 4, 2, 14, 12, 10, 4, 2, 0};

    // Clock at 200 MHz
    always #2.5 mclk = ~mclk;

    interrupt_priority_fields u_interrupt_priority_fields (
        .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .src_request(src_request),
        .src_tagged(src_tagged)
    );
    irq_core_model u_irq_core_model (
        .mclk(mclk), .reset_n(reset_n), .src_tagged(src_tagged),
        .taken_count(taken_count), .bad_level(bad_level)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [4:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    function automatic logic [15:0] valids();
        logic [15:0] v;
        v = 16'h0000;
        for (int i = 0; i < NS; i++)
            v[i] = src_tagged[i].valid;
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset_values();
        logic [15:0] d;
        for (int a = 2; a <= 4; a++)
        begin
            reg_read(5'(a), d);
            check(d, 16'h0000);
        end
        check(valids(), 16'h0000);
    endtask

    // Reserved bits drop on write, unmapped places stay empty
    task automatic test_reserved();
        logic [15:0] d;
        logic [15:0] mask [3] = '{16'h0fc3, 16'h03fc, 16'hfc3f};
        for (int a = 2; a <= 4; a++)
        begin
            reg_write(5'(a), 16'hffff);
            reg_read(5'(a), d);
            check(d, mask[a-2]);
        end
        reg_write(5'h05, 16'hffff);
        reg_read(5'h05, d);
        check(d, 16'h0000);
        for (int a = 2; a <= 4; a++)
            reg_write(5'(a), 16'h0000);
    endtask

    // Write, then read and request with no gap, on every register
    task automatic test_back_to_back();
        logic [15:0] wd [3] = '{16'hfa7d, 16'hfe93, 16'h9fd5};
        logic [15:0] exp_rd [3] = '{16'h0a41, 16'h0290, 16'h9c15};
        logic [15:0] rq [3] = '{16'h0002, 16'h0020, 16'h2200};
        for (int a = 2; a <= 4; a++)
        begin
            @(posedge mclk);
            reg_wr <= 1'b1;
            reg_addr <= 5'(a);
            reg_wdata <= wd[a-2];
            @(posedge mclk);
            reg_wr <= 1'b0;
            reg_rd <= 1'b1;
            src_request <= rq[a-2][NS-1:0];
            @(posedge mclk);
            reg_rd <= 1'b0;
            src_request <= '0;
            #1 check(reg_rdata, exp_rd[a-2]);
            check(valids(), rq[a-2]);
            @(posedge mclk);
            #1 check(reg_rdata, 16'h0000);
            reg_write(5'(a), 16'h0000);
        end
    endtask

    // Every code on every field: placement, decode and request tagging
    task automatic test_fields();
        logic [15:0] d;
        logic [15:0] v;
        for (int i = 0; i < NS; i++)
        begin
            for (int c = 0; c < 4; c++)
            begin
                v = 16'(c) << src_lsb[i];
                reg_write(src_addr[i], v);
                reg_read(src_addr[i], d);
                check(d, v);
                @(posedge mclk);
                src_request <= NS'(1) << i;
                @(posedge mclk);
                src_request <= '0;
                #1 check(valids(), (c == 0) ? 16'h0 : 16'h1 << i);
                if (c != 0)
                    check({14'h0, src_tagged[i].level}, 16'(c - 1));
            end
            reg_write(src_addr[i], 16'h0000);
        end
    endtask

    // All sources at code 11 requesting for three cycles together
    task automatic test_all_high();
        logic [31:0] base;
        for (int a = 2; a <= 4; a++)
            reg_write(5'(a), 16'hffff);
        base = taken_count;
        @(posedge mclk);
        src_request <= '1;
        for (int k = 0; k < 3; k++)
        begin
            @(posedge mclk);
            if (k == 2)
                src_request <= '0;
            #1 check(valids(), 16'h3fff);
            for (int i = 0; i < NS; i++)
                check({14'h0, src_tagged[i].level}, 16'h0002);
        end
        @(posedge mclk);
        #1 check(valids(), 16'h0000);
        check(16'(taken_count - base), 16'd42);
        check({15'h0, bad_level}, 16'h0000);
    endtask

    // Reset in mid-run returns every field to disabled
    task automatic test_mid_reset();
        @(posedge mclk);
        src_request <= '1;
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        #1 check(valids(), 16'h0000);
        repeat (2) @(posedge mclk);
        src_request <= '0;
        #1 check(valids(), 16'h0000);
        test_reset_values();
    endtask

    // Watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        finish_test();
    end

    initial
    begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        test_reset_values();
        test_reserved();
        test_back_to_back();
        test_fields();
        test_all_high();
        test_mid_reset();
        finish_test();
    end
endmodule // tb_interrupt_priority_fields
`default_nettype wire
